// >>> src/stop_power_pkg.sv
// Shared constants and types of the stop-mode power controller
package stop_power_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] CTRL_OFS    = 5'h00;
	localparam logic [4:0] DBGCTRL_OFS = 5'h04;
	localparam logic [4:0] STATUS_OFS  = 5'h08;
	localparam logic [4:0] ACK_OFS     = 5'h0C;
	localparam logic [4:0] KEYEN_OFS   = 5'h10;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int STOP_PERMIT_BIT = 0;
	localparam int PPD_SEL_BIT     = 1;
	localparam int DET_EN_BIT      = 2;
	localparam int DET_STOP_BIT    = 3;
	localparam int DET_RST_SEL_BIT = 4;
	localparam int OSC_STOP_BIT    = 5;
	localparam int HIGH_RANGE_BIT  = 6;
	localparam int ADC_ASYNC_BIT   = 7;
	localparam int TIMER_SEL_BIT   = 8;
	localparam int TIMER_EN_BIT    = 9;
	localparam int DBG_EN_BIT      = 0;
	localparam int PPD_ACK_BIT     = 0;
	localparam int ST_FLAG_BIT     = 2;
	localparam int ST_HOLD_BIT     = 3;
	localparam int ST_LVIRQ_BIT    = 4;
	localparam int ST_LVRST_BIT    = 5;
	// ------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK   = 32'h0000_03FF;
	localparam logic [31:0] DBGCTRL_RST = 32'h0000_0000;
	localparam logic [31:0] KEYEN_RST   = 32'h0000_0000;
	localparam logic        TIMER_SEL_INTERNAL = 1'b0;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_RET   = 2'b01,
		ST_DEEP  = 2'b10,
		ST_DEBUG = 2'b11
	} pwr_state_t;
	typedef enum logic [2:0] {
		CMD_MEM         = 3'b000,
		CMD_MEM_STATUS  = 3'b001,
		CMD_REG         = 3'b010,
		CMD_ENTER_DEBUG = 3'b011,
		CMD_ACTIVE      = 3'b100,
		CMD_GO          = 3'b101
	} dbg_cmd_t;
endpackage

// >>> src/power_cfg_if.sv
// Internal carrier between controller, level selector and command gate
`timescale 1ns/1ns
interface power_cfg_if;
	import stop_power_pkg::*;
	logic     ppdSel, dbgEn, detStop, oscStop, highRange, adcAsync, timerSel, timerEn;
	logic     deepLevel, adcKeep, oscKeep, timerKeepDeep, timerKeepRet;
	logic     cmdValid, stopped, inDebug;
	dbg_cmd_t cmdCode;
	logic     cmdAccept, cmdRefuse, memErr, enterDebug, leaveDebug;
	modport ctl (output ppdSel, dbgEn, detStop, oscStop, highRange, adcAsync, timerSel,
		timerEn, cmdValid, cmdCode, stopped, inDebug,
		input deepLevel, adcKeep, oscKeep, timerKeepDeep, timerKeepRet,
		cmdAccept, cmdRefuse, memErr, enterDebug, leaveDebug);
	modport sel (input ppdSel, dbgEn, detStop, oscStop, highRange, adcAsync, timerSel,
		timerEn, output deepLevel, adcKeep, oscKeep, timerKeepDeep, timerKeepRet);
	modport dbg (input cmdValid, cmdCode, stopped, inDebug, dbgEn,
		output cmdAccept, cmdRefuse, memErr, enterDebug, leaveDebug);
endinterface

// >>> src/stop_level_select.sv
// Stop level choice and retained- and deep-stop resource keep-alive decisions
`timescale 1ns/1ns
module stop_level_select (
	power_cfg_if.sel cfg // Configuration in, decisions out
);
	import stop_power_pkg::*;
	always_comb begin
		// Debug or detector-in-stop demote the deep level
		cfg.deepLevel = cfg.ppdSel & ~cfg.dbgEn & ~cfg.detStop;
		cfg.adcKeep = cfg.adcAsync & cfg.detStop;
		// High range oscillator needs the detector's regulator kept up
		cfg.oscKeep = cfg.oscStop & (~cfg.highRange | cfg.detStop);
		cfg.timerKeepDeep = cfg.timerEn & (cfg.timerSel == TIMER_SEL_INTERNAL);
		cfg.timerKeepRet = cfg.timerEn
			& ((cfg.timerSel == TIMER_SEL_INTERNAL) | cfg.oscStop);
	end
endmodule

// >>> src/debug_cmd_gate.sv
// Accept or refuse serial debug commands by power state
`timescale 1ns/1ns
module debug_cmd_gate (
	power_cfg_if.dbg cmd // Command in, verdict out
);
	import stop_power_pkg::*;
	always_comb begin
		cmd.cmdAccept  = 1'b0;
		cmd.cmdRefuse  = 1'b0;
		cmd.memErr     = 1'b0;
		cmd.enterDebug = 1'b0;
		cmd.leaveDebug = 1'b0;
		if (cmd.cmdValid) begin
			if (cmd.inDebug) begin
				cmd.cmdAccept  = 1'b1;
				cmd.leaveDebug = (cmd.cmdCode == CMD_GO);
			end else if (cmd.stopped) begin
				case (cmd.cmdCode)
					CMD_ENTER_DEBUG: begin
						cmd.cmdAccept  = cmd.dbgEn;
						cmd.cmdRefuse  = ~cmd.dbgEn;
						cmd.enterDebug = cmd.dbgEn;
					end
					CMD_MEM_STATUS: begin
						// No memory access, only the stopped status
						cmd.cmdRefuse = 1'b1;
						cmd.memErr    = 1'b1;
					end
					default: cmd.cmdRefuse = 1'b1;
				endcase
			end else begin
				case (cmd.cmdCode)
					CMD_ENTER_DEBUG: begin
						cmd.cmdAccept  = cmd.dbgEn;
						cmd.cmdRefuse  = ~cmd.dbgEn;
						cmd.enterDebug = cmd.dbgEn;
					end
					CMD_MEM, CMD_MEM_STATUS, CMD_REG: cmd.cmdAccept = 1'b1;
					default: cmd.cmdRefuse = 1'b1;
				endcase
			end
		end
	end
endmodule

// >>> src/stop_power_ctrl.sv
// Stop-mode power controller with Avalon-MM register slave
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
module stop_power_ctrl #(
	parameter int KEY_N = 8
) (
	input  wire logic                      clk,            // System clock
	input  wire logic                      srst,           // Sync reset
	input  wire logic [4:0]                avs_address,    // Byte address
	input  wire logic                      avs_read,       // Read request
	input  wire logic                      avs_write,      // Write request
	input  wire logic [31:0]               avs_writedata,  // Write data
	input  wire logic [3:0]                avs_byteenable, // Byte lanes
	output logic [31:0]                    avs_readdata,   // Read data
	output logic                           avs_waitrequest,// Stall
	input  wire logic                      stopExec,       // Stop instruction
	input  wire logic                      wakeTimerTick,  // Wake timer event
	input  wire logic                      adcDoneIrq,     // Converter event
	input  wire logic                      irqPin_n,       // Async wake pin
	input  wire logic                      lowVoltPin,     // Async comparator
	input  wire logic [KEY_N-1:0]          keyPins,        // Async keypad pins
	input  wire logic                      dbgCmdValid,    // Debug command
	input  wire stop_power_pkg::dbg_cmd_t  dbgCmdCode,     // Command kind
	output logic                           dbgCmdAccept,   // Taken
	output logic                           dbgCmdRefuse,   // Rejected
	output logic                           dbgStopErr,     // Stopped status
	output logic                           debugActive,    // Debug state
	output logic                           illegalOpReset, // Reset pulse
	output logic                           deepWakeReset,  // Reset pulse
	output logic                           lowVoltIrq,     // Detector irq
	output logic                           lowVoltReset,   // Detector reset
	output logic                           coreDomainOn,   // Core powered
	output logic                           coreStandby,    // Core retained
	output logic                           cpuClkEn,       // CPU clock
	output logic                           periphClkEn,    // Peripheral clocks
	output logic                           debugClkEn,     // Debug clocks
	output logic                           regulatorFull,  // Full regulation
	output logic                           adcRun,         // Converter on
	output logic                           oscRun,         // Oscillator on
	output logic                           wakeTimerRun,   // Timer on
	output logic [KEY_N-1:0]               keypadWakeArm,  // Armed pins
	output logic                           pinHold         // Pins latched
);
	import stop_power_pkg::*;

	power_cfg_if pc ();
	stop_level_select u_sel (.cfg(pc.sel));
	debug_cmd_gate u_gate (.cmd(pc.dbg));

	// ------------------------------------------------------------
	// Registers and bus slave
	// ------------------------------------------------------------
	logic [31:0] ctrl_r, dbgCtrl_r, keyEn_r;
	logic        ackPhase_r;
	logic        busWr, ackWrite;
	logic        stopPermit, detEn, detRstSel;
	pwr_state_t  state_r, state_nxt;
	logic        ppdFlag_r, dbgAtStop_r, detAtStop_r;
	logic        adcKeep_r, oscKeep_r, timerKeep_r;
	logic        stopTaken, dbgKeep, detKeep, adcKeepNow, oscKeepNow, timerKeepNow;
	localparam logic [31:0] KEY_MASK = {{(32 - KEY_N){1'b0}}, {KEY_N{1'b1}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// One wait state: the answer comes on the second edge of a request
	assign avs_waitrequest = (avs_read | avs_write) & ~ackPhase_r;
	assign busWr = avs_write & ackPhase_r;
	assign ackWrite = busWr & (avs_address == ACK_OFS) & avs_byteenable[0]
		& avs_writedata[PPD_ACK_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			ackPhase_r <= 1'b0;
		end else begin
			ackPhase_r <= (avs_read | avs_write) & ~ackPhase_r;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r    <= CTRL_RST;
			dbgCtrl_r <= DBGCTRL_RST;
			keyEn_r   <= KEYEN_RST;
		end else if (busWr) begin
			case (avs_address)
				CTRL_OFS: ctrl_r <= merge(ctrl_r, avs_writedata, avs_byteenable) & CTRL_MASK;
				DBGCTRL_OFS: dbgCtrl_r[DBG_EN_BIT] <= avs_byteenable[0]
					? avs_writedata[DBG_EN_BIT] : dbgCtrl_r[DBG_EN_BIT];
				KEYEN_OFS: keyEn_r <= merge(keyEn_r, avs_writedata, avs_byteenable)
					& KEY_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ackPhase_r) begin
			avs_readdata <= 32'h0000_0000;
			case (avs_address)
				CTRL_OFS:    avs_readdata <= ctrl_r;
				DBGCTRL_OFS: avs_readdata <= dbgCtrl_r;
				KEYEN_OFS:   avs_readdata <= keyEn_r;
				STATUS_OFS: begin
					avs_readdata[1:0]          <= state_r;
					avs_readdata[ST_FLAG_BIT]  <= ppdFlag_r;
					avs_readdata[ST_HOLD_BIT]  <= pinHold;
					avs_readdata[ST_LVIRQ_BIT] <= lowVoltIrq;
					avs_readdata[ST_LVRST_BIT] <= lowVoltReset;
				end
				default: ;
			endcase
		end
	end

	assign stopPermit = ctrl_r[STOP_PERMIT_BIT];
	assign detEn      = ctrl_r[DET_EN_BIT];
	assign detRstSel  = ctrl_r[DET_RST_SEL_BIT];
	assign pc.ppdSel    = ctrl_r[PPD_SEL_BIT];
	assign pc.dbgEn     = dbgCtrl_r[DBG_EN_BIT];
	assign pc.detStop   = detEn & ctrl_r[DET_STOP_BIT];
	assign pc.oscStop   = ctrl_r[OSC_STOP_BIT];
	assign pc.highRange = ctrl_r[HIGH_RANGE_BIT];
	assign pc.adcAsync  = ctrl_r[ADC_ASYNC_BIT];
	assign pc.timerSel  = ctrl_r[TIMER_SEL_BIT];
	assign pc.timerEn   = ctrl_r[TIMER_EN_BIT];
	assign pc.cmdValid  = dbgCmdValid;
	assign pc.cmdCode   = dbgCmdCode;
	assign pc.stopped   = (state_r == ST_RET) | (state_r == ST_DEEP);
	assign pc.inDebug   = (state_r == ST_DEBUG);

	// ------------------------------------------------------------
	// Pin synchronisers and wake sources
	// ------------------------------------------------------------
	logic             irqMeta_r, irqSync_r, lvMeta_r, lvSync_r;
	logic [KEY_N-1:0] keyMeta_r, keySync_r, keyWake;
	logic             detTrip, retWake, deepWake;

	always_ff @(posedge clk) begin
		if (srst) begin
			irqMeta_r <= 1'b1;
			irqSync_r <= 1'b1;
			lvMeta_r  <= 1'b0;
			lvSync_r  <= 1'b0;
		end else begin
			irqMeta_r <= irqPin_n;
			irqSync_r <= irqMeta_r;
			lvMeta_r  <= lowVoltPin;
			lvSync_r  <= lvMeta_r;
		end
	end

	for (genvar k = 0; k < KEY_N; k++) begin : g_key
		always_ff @(posedge clk) begin
			if (srst) begin
				keyMeta_r[k] <= 1'b0;
				keySync_r[k] <= 1'b0;
			end else begin
				keyMeta_r[k] <= keyPins[k];
				keySync_r[k] <= keyMeta_r[k];
			end
		end
		assign keyWake[k] = keySync_r[k] & keyEn_r[k];
	end

	// In stop the detector only counts when armed at entry
	assign detTrip = lvSync_r & detEn & (pc.stopped ? detAtStop_r : 1'b1);
	assign retWake = ~irqSync_r | detTrip | (adcDoneIrq & adcRun) | (|keyWake)
		| (wakeTimerTick & wakeTimerRun);
	assign deepWake = ~irqSync_r | (wakeTimerTick & wakeTimerRun);

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (stopExec & stopPermit) begin
					state_nxt = pc.deepLevel ? ST_DEEP : ST_RET;
				end else if (pc.enterDebug) begin
					state_nxt = ST_DEBUG;
				end
			end
			ST_RET: begin
				if (pc.enterDebug) begin
					state_nxt = ST_DEBUG;
				end else if (retWake) begin
					state_nxt = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (deepWake) begin
					state_nxt = ST_RUN;
				end
			end
			ST_DEBUG: begin
				if (pc.leaveDebug) begin
					state_nxt = ST_RUN;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Settings frozen at the stop instruction, not tracked during stop
	assign stopTaken    = (state_r == ST_RUN) & stopExec & stopPermit;
	// Entry edge reads live settings: the frozen copy only lands on that edge
	assign dbgKeep      = stopTaken ? pc.dbgEn : dbgAtStop_r;
	assign detKeep      = stopTaken ? pc.detStop : detAtStop_r;
	assign adcKeepNow   = stopTaken ? pc.adcKeep : adcKeep_r;
	assign oscKeepNow   = stopTaken ? pc.oscKeep : oscKeep_r;
	assign timerKeepNow = stopTaken ? (pc.deepLevel ? pc.timerKeepDeep : pc.timerKeepRet)
		: timerKeep_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			dbgAtStop_r <= 1'b0;
			detAtStop_r <= 1'b0;
			adcKeep_r   <= 1'b0;
			oscKeep_r   <= 1'b0;
			timerKeep_r <= 1'b0;
		end else if (stopTaken) begin
			dbgAtStop_r <= dbgKeep;
			detAtStop_r <= detKeep;
			adcKeep_r   <= adcKeepNow;
			oscKeep_r   <= oscKeepNow;
			timerKeep_r <= timerKeepNow;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			illegalOpReset <= 1'b0;
			deepWakeReset  <= 1'b0;
		end else begin
			illegalOpReset <= (state_r == ST_RUN) & stopExec & ~stopPermit;
			deepWakeReset  <= (state_r == ST_DEEP) & deepWake;
		end
	end

	// Set beats acknowledge in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			ppdFlag_r <= 1'b0;
			pinHold   <= 1'b0;
		end else begin
			if ((state_r == ST_DEEP) & deepWake) begin
				ppdFlag_r <= 1'b1;
			end else if (ackWrite) begin
				ppdFlag_r <= 1'b0;
			end
			if (state_nxt == ST_DEEP) begin
				pinHold <= 1'b1;
			end else if (ackWrite & (state_r != ST_DEEP)) begin
				pinHold <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Domain outputs, registered from the next state
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			coreDomainOn  <= 1'b1;
			coreStandby   <= 1'b0;
			cpuClkEn      <= 1'b1;
			periphClkEn   <= 1'b1;
			debugClkEn    <= 1'b1;
			regulatorFull <= 1'b1;
			adcRun        <= 1'b1;
			oscRun        <= 1'b1;
			wakeTimerRun  <= 1'b0;
			keypadWakeArm <= '0;
			debugActive   <= 1'b0;
		end else begin
			coreDomainOn  <= (state_nxt != ST_DEEP);
			coreStandby   <= (state_nxt == ST_RET);
			cpuClkEn      <= (state_nxt == ST_RUN);
			periphClkEn   <= (state_nxt == ST_RUN) | (state_nxt == ST_DEBUG);
			debugClkEn    <= (state_nxt == ST_RUN) | (state_nxt == ST_DEBUG)
				| ((state_nxt == ST_RET) & dbgKeep);
			regulatorFull <= (state_nxt == ST_RUN) | (state_nxt == ST_DEBUG)
				| ((state_nxt == ST_RET) & (dbgKeep | detKeep));
			adcRun        <= (state_nxt == ST_RUN) | (state_nxt == ST_DEBUG)
				| ((state_nxt == ST_RET) & adcKeepNow);
			oscRun        <= (state_nxt == ST_RUN) | (state_nxt == ST_DEBUG)
				| ((state_nxt == ST_RET) & (oscKeepNow | dbgKeep));
			// Stopped timer follows the frozen keep decision, not the live enable
			wakeTimerRun  <= ((state_nxt == ST_RUN) | (state_nxt == ST_DEBUG)) ? pc.timerEn
				: timerKeepNow;
			keypadWakeArm <= (state_nxt == ST_RET) ? keyEn_r[KEY_N-1:0] : '0;
			debugActive   <= (state_nxt == ST_DEBUG);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dbgCmdAccept <= 1'b0;
			dbgCmdRefuse <= 1'b0;
			dbgStopErr   <= 1'b0;
			lowVoltIrq   <= 1'b0;
			lowVoltReset <= 1'b0;
		end else begin
			dbgCmdAccept <= pc.cmdAccept;
			dbgCmdRefuse <= pc.cmdRefuse;
			dbgStopErr   <= pc.memErr;
			lowVoltIrq   <= detTrip & ~detRstSel;
			lowVoltReset <= detTrip & detRstSel;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_illegal_stop;
		@(posedge clk) disable iff (srst)
		(state_r == ST_RUN && stopExec && !stopPermit) |=> illegalOpReset && state_r == ST_RUN;
	endproperty
	a_illegal_stop: assert property (p_illegal_stop) else $error("no illegal reset");

	property p_dbg_demotes;
		@(posedge clk) disable iff (srst)
		(state_r == ST_RUN && stopExec && stopPermit && pc.dbgEn) |=> state_r == ST_RET;
	endproperty
	a_dbg_demotes: assert property (p_dbg_demotes) else $error("deep stop with debug");

	property p_det_demotes;
		@(posedge clk) disable iff (srst)
		(state_r == ST_RUN && stopExec && stopPermit && pc.detStop) |=> state_r == ST_RET;
	endproperty
	a_det_demotes: assert property (p_det_demotes) else $error("deep stop with detector");

	property p_deep_select;
		@(posedge clk) disable iff (srst)
		(state_r == ST_RUN && stopExec && stopPermit && pc.ppdSel && !pc.dbgEn && !pc.detStop)
			|=> state_r == ST_DEEP ##0 !coreDomainOn && pinHold;
	endproperty
	a_deep_select: assert property (p_deep_select) else $error("deep stop not entered");

	property p_periph_gated;
		@(posedge clk) disable iff (srst)
		pc.stopped |-> !periphClkEn && !cpuClkEn;
	endproperty
	a_periph_gated: assert property (p_periph_gated) else $error("clocks run in stop");

	property p_regulator;
		@(posedge clk) disable iff (srst)
		(state_r == ST_RET && (dbgAtStop_r || detAtStop_r)) |-> regulatorFull;
	endproperty
	a_regulator: assert property (p_regulator) else $error("regulator dropped");

	property p_hold_until_ack;
		@(posedge clk) disable iff (srst)
		(state_r == ST_DEEP && deepWake) |=> ppdFlag_r && pinHold && state_r == ST_RUN
			##1 (ppdFlag_r && pinHold) [*2];
	endproperty
	a_hold_until_ack: assert property (p_hold_until_ack) else $error("hold lost");

	property p_stop_status_err;
		@(posedge clk) disable iff (srst)
		(dbgCmdValid && dbgCmdCode == CMD_MEM_STATUS && pc.stopped)
			|=> dbgStopErr && dbgCmdRefuse && !dbgCmdAccept;
	endproperty
	a_stop_status_err: assert property (p_stop_status_err) else $error("no stop error");

	property p_debug_wake;
		@(posedge clk) disable iff (srst)
		(dbgCmdValid && dbgCmdCode == CMD_ENTER_DEBUG && pc.stopped && pc.dbgEn)
			|=> state_r == ST_DEBUG && debugActive && dbgCmdAccept;
	endproperty
	a_debug_wake: assert property (p_debug_wake) else $error("no debug wake");
endmodule

// >>> tb/core_debug_host.sv
// Model of the CPU core and serial debug host
`timescale 1ns/1ns
module core_debug_host
	import stop_power_pkg::*;
(
	input  wire logic clk,         // System clock
	output logic      stopExec,    // Stop instruction pulse
	output logic      dbgCmdValid, // Command strobe
	output dbg_cmd_t  dbgCmdCode   // Command kind
);
	initial begin
		stopExec = 1'h0;
		dbgCmdValid = 1'h0;
		dbgCmdCode = CMD_MEM;
	end
	task automatic stop_now();
		stopExec <= 1'h1;
		@(posedge clk);
		stopExec <= 1'h0;
	endtask
	// Released code shows its inverse, never a stale value
	task automatic send(input dbg_cmd_t c);
		dbgCmdValid <= 1'h1;
		dbgCmdCode <= c;
		@(posedge clk);
		dbgCmdValid <= 1'h0;
		dbgCmdCode <= dbg_cmd_t'(~c);
	endtask
endmodule

// >>> tb/tb_stop_power_ctrl.sv
// Self-checking bench of the stop-mode power controller
`timescale 1ns/1ns
module tb_stop_power_ctrl;
	import stop_power_pkg::*;
	logic clk = 1'h0, srst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
	logic [4:0] avs_address = 5'h00;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
	logic wakeTimerTick = 1'h0, adcDoneIrq = 1'h0, irqPin_n = 1'h1, lowVoltPin = 1'h0;
	logic [7:0] keyPins = 8'h00, keypadWakeArm;
	logic avs_waitrequest, stopExec, dbgCmdValid, dbgCmdAccept, dbgCmdRefuse, dbgStopErr;
	logic debugActive, illegalOpReset, deepWakeReset, lowVoltIrq, lowVoltReset, pinHold;
	logic coreDomainOn, coreStandby, cpuClkEn, periphClkEn, debugClkEn, regulatorFull;
	logic adcRun, oscRun, wakeTimerRun;
	dbg_cmd_t dbgCmdCode;
	int badCount = 0, compares = 0, cyc = 0;
	stop_power_ctrl dut (.*);
	core_debug_host host (.*);
	always #10 clk = ~clk;
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		if (badCount == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Hang guard, well above the fewer than one hundred cycles used
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			badCount++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected %s expected %0h seen %0h", n, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0) @(posedge clk);
		rdata = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic stop();
		@(posedge clk);
		host.stop_now();
		#1;
	endtask
	// Verdict bits: stop error, refuse, accept
	task automatic cmd(input dbg_cmd_t c, input logic [2:0] e);
		@(posedge clk);
		host.send(c);
		#1;
		chk("cmd verdict", {dbgStopErr, dbgCmdRefuse, dbgCmdAccept}, {29'h0, e});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		bus(1'h0, CTRL_OFS, 32'h0);
		chk("ctrl reset", rdata, CTRL_RST);
		bus(1'h1, CTRL_OFS, 32'hFFFF_FFFF);
		bus(1'h0, CTRL_OFS, 32'h0);
		chk("ctrl mask", rdata, CTRL_MASK);
		bus(1'h0, 5'h14, 32'h0);
		chk("unmapped", rdata, 32'h0);
		bus(1'h1, CTRL_OFS, 32'h0);
		stop();
		chk("illegal reset", illegalOpReset, 1'h1);
		chk("no stop", coreStandby, 1'h0);
	endtask
	task automatic t_deep();
		bus(1'h1, CTRL_OFS, 32'h203);
		stop();
		chk("deep core", coreDomainOn, 1'h0);
		chk("deep periph", periphClkEn, 1'h0);
		chk("deep cpu clk", cpuClkEn, 1'h0);
		chk("deep timer", wakeTimerRun, 1'h1);
		@(posedge clk);
		wakeTimerTick <= 1'h1;
		@(posedge clk);
		wakeTimerTick <= 1'h0;
		#1;
		chk("deep wake", deepWakeReset, 1'h1);
		bus(1'h0, STATUS_OFS, 32'h0);
		chk("flag hold", rdata[3:0], 4'hC);
		bus(1'h1, ACK_OFS, 32'h1);
		bus(1'h0, STATUS_OFS, 32'h0);
		chk("acked", rdata[3:0], 4'h0);
	endtask
	task automatic t_debug();
		bus(1'h1, DBGCTRL_OFS, 32'h1);
		bus(1'h1, CTRL_OFS, 32'h3);
		stop();
		chk("dbg retained", coreStandby, 1'h1);
		chk("dbg clocks", debugClkEn, 1'h1);
		chk("dbg regulator", regulatorFull, 1'h1);
		chk("dbg periph", periphClkEn, 1'h0);
		cmd(CMD_MEM_STATUS, 3'h6);
		cmd(CMD_REG, 3'h2);
		cmd(CMD_ENTER_DEBUG, 3'h1);
		chk("in debug", debugActive, 1'h1);
		cmd(CMD_ACTIVE, 3'h1);
		cmd(CMD_GO, 3'h1);
		bus(1'h1, DBGCTRL_OFS, 32'h0);
		cmd(CMD_ENTER_DEBUG, 3'h2);
		chk("no debug", debugActive, 1'h0);
	endtask
	task automatic t_lvd();
		bus(1'h1, KEYEN_OFS, 32'h1);
		bus(1'h1, CTRL_OFS, 32'h8F);
		stop();
		chk("lvd retained", coreStandby, 1'h1);
		chk("lvd regulator", regulatorFull, 1'h1);
		chk("adc kept", adcRun, 1'h1);
		chk("osc off", oscRun, 1'h0);
		chk("keypad armed", keypadWakeArm, 8'h01);
		@(posedge clk);
		keyPins <= 8'h01;
		repeat (6) @(posedge clk);
		keyPins <= 8'h00;
		bus(1'h0, STATUS_OFS, 32'h0);
		chk("keypad wake", rdata[1:0], 2'h0);
		lowVoltPin <= 1'h1;
		repeat (5) @(posedge clk);
		#1;
		chk("low volt irq", lowVoltIrq, 1'h1);
		chk("low volt reset", lowVoltReset, 1'h0);
		bus(1'h1, CTRL_OFS, 32'h9F);
		@(posedge clk);
		#1;
		chk("low volt reset sel", lowVoltReset, 1'h1);
		chk("low volt irq off", lowVoltIrq, 1'h0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		t_regs();
		t_deep();
		t_debug();
		t_lvd();
		tally_and_finish();
	end
endmodule
